// File: hdl/vtf_map.vh
// Register offsets, field positions, reset values and codes of the VLAN tag filter engine
`ifndef VTF_MAP_VH
`define VTF_MAP_VH
`define VTF_A_MGMT 8'h00
`define VTF_A_VCMD 8'h04
`define VTF_A_VDATA 8'h08
`define VTF_A_VQUERY 8'h0C
`define VTF_A_PCFG 8'h10
`define VTF_A_PTPID 8'h20
`define VTF_A_SPAN 8'h30
`define VTF_MGMT_RST 12'h001
`define VTF_PORT_DEFAULT_VLAN_ID_RST 12'h001
`define VTF_TPID_RST 16'h8100
`define VTF_DEF_VID 12'h001
`define VTF_VID_MIN 12'h001
`define VTF_VID_MAX 12'hFFE
`define VTF_MAX_VLANS 9'h100
`define VTF_NPORTS 4
`define VTF_NSLOTS 256
`define VTF_EGR_NONE 2'h0
`define VTF_EGR_UNTAG 2'h1
`define VTF_EGR_TAG 2'h2
`define VTF_EGR_ALL_UNTAG 8'h55
`define VTF_TUN_NONE 2'h0
`define VTF_TUN_CUST 2'h1
`define VTF_TUN_UPLINK 2'h2
`define VTF_PVT_NONE 2'h0
`define VTF_PVT_PRIMARY 2'h1
`define VTF_PVT_ISOLATED 2'h2
`define VTF_PVT_COMMUNITY 2'h3
`define VTF_PPT_PROMISC 2'h2
`define VTF_OP_CREATE 2'h1
`define VTF_OP_DELETE 2'h2
`define VTF_OP_SET 2'h3
`define VTF_CMD_OP_LSB 12
`define VTF_PCFG_TUN_LSB 12
`define VTF_PCFG_TAGONLY_BIT 14
`define VTF_PCFG_FILT_BIT 15
`define VTF_PCFG_PPT_LSB 16
`define VTF_VDATA_PVT_LSB 8
`define VTF_VDATA_PRIM_LSB 10
`define VTF_STAT_CNT_LSB 4
`define VTF_RESP_OKAY 2'h0
`define VTF_RESP_SLVERR 2'h2
`endif

// File: hdl/vtf_axil.v
// AXI4-Lite slave front end that turns bus transfers into register strobes
`include "vtf_map.vh"
module vtf_axil (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire [31:0] rd_word,
    input wire rd_ok,
    input wire wr_ok,
    output reg reg_we,
    output reg [7:0] reg_waddr,
    output reg [31:0] reg_wdata,
    output reg [31:0] reg_wmask
);
    reg aw_full;
    reg w_full;
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `VTF_RESP_OKAY;
            reg_we <= 1'b0;
            reg_waddr <= 8'h00;
            reg_wdata <= 32'h00000000;
            reg_wmask <= 32'h00000000;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `VTF_RESP_OKAY;
        end else begin
            reg_we <= 1'b0;
            if (awvalid && awready) begin
                reg_waddr <= awaddr;
                aw_full <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                reg_wdata <= wdata;
                reg_wmask <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
                w_full <= 1'b1;
                wready <= 1'b0;
            end
            // Both halves held: commit once and answer
            if (aw_full && w_full && !bvalid) begin
                reg_we <= wr_ok;
                bresp <= wr_ok ? `VTF_RESP_OKAY : `VTF_RESP_SLVERR;
                bvalid <= 1'b1;
                aw_full <= 1'b0;
                w_full <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (arvalid && arready) begin
                rdata <= rd_ok ? rd_word : 32'h00000000;
                rresp <= rd_ok ? `VTF_RESP_OKAY : `VTF_RESP_SLVERR;
                rvalid <= 1'b1;
                arready <= 1'b0;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// File: hdl/vtf_engine.v
// VLAN classification, admission, filtering and egress tagging engine
//
// Contract
// - VLAN IDs 1 to 4094 alone are accepted for creation and configuration, and VLAN 1 exists as default.
// - A management VLAN ID, 1 after reset, decides which ingress ports may reach the CPU.
// - At most 256 VLANs exist at once and a create beyond that is refused.
// - A new VLAN reads as unused until at least one port is made a member.
// - Each VLAN keeps per port an egress setting of not-member, untagged or tagged.
// - A frame's VLAN comes from its tag and it is forwarded only to member ports of that VLAN.
// - Each port has a default VLAN ID given to untagged frames arriving on it.
// - Each port has tunnel mode none, customer tunnel or provider uplink, none adding no service tag work.
// - A customer tunnel port pushes an outer tag with its default VLAN ID and strips it toward the customer.
// - Customer tunnel ports egress untagged and provider uplink ports always egress with the outer tag.
// - The double tagging protocol identifier is set per port and defaults to 0x8100.
// - Admit-all mode takes tagged and untagged frames and tagged-only mode drops untagged frames.
// - With ingress filtering on, a tagged frame is dropped unless the ingress port is a member of its VLAN.
// - Each VLAN has a private type none, primary, isolated or community, none being unrestricted.
// - Promiscuous ports of a primary VLAN exchange frames with its associated secondary VLANs.
// - Community members forward among themselves while isolated members never reach each other.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`include "vtf_map.vh"
module vtf_engine (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    input wire cls_valid,
    input wire [1:0] cls_port,
    input wire cls_tagged,
    input wire [11:0] cls_vid,
    output reg res_valid,
    output reg res_drop,
    output reg [11:0] res_vid,
    output reg [3:0] res_fwd_mask,
    output reg [3:0] res_tag_mask,
    output reg [3:0] res_strip_mask,
    output reg res_push_tag,
    output reg [31:0] res_tag_word,
    output reg res_cpu_ok
);
    reg tbl_valid [0:`VTF_NSLOTS-1];
    reg [11:0] tbl_vid [0:`VTF_NSLOTS-1];
    reg [7:0] tbl_egr [0:`VTF_NSLOTS-1];
    reg [1:0] tbl_pvt [0:`VTF_NSLOTS-1];
    reg [11:0] tbl_prim [0:`VTF_NSLOTS-1];
    reg [17:0] pcfg [0:`VTF_NPORTS-1];
    reg [15:0] ptpid [0:`VTF_NPORTS-1];
    reg [11:0] mgmt_vid;
    reg [21:0] vdata;
    reg [11:0] query_vid;
    reg refused;
    wire reg_we;
    wire [7:0] reg_waddr;
    wire [31:0] reg_wdata;
    wire [31:0] reg_wmask;
    reg [31:0] rd_word;
    reg rd_ok;
    wire wr_ok;
    reg [31:0] wr_new;
    integer i;
    integer j;
    integer n;

    vtf_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rd_word(rd_word),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok),
        .reg_we(reg_we),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wmask(reg_wmask)
    );

    function [3:0] members;
        input [7:0] egr;
        integer k;
        begin
            for (k = 0; k < `VTF_NPORTS; k = k + 1) begin
                members[k] = (egr[2*k +: 2] != `VTF_EGR_NONE);
            end
        end
    endfunction

    function [3:0] tagged_ports;
        input [7:0] egr;
        integer k;
        begin
            for (k = 0; k < `VTF_NPORTS; k = k + 1) begin
                tagged_ports[k] = (egr[2*k +: 2] == `VTF_EGR_TAG);
            end
        end
    endfunction

    function vid_legal;
        input [11:0] v;
        begin
            vid_legal = (v >= `VTF_VID_MIN) && (v <= `VTF_VID_MAX);
        end
    endfunction

    // Per-port views of the port configuration
    reg [3:0] promisc;
    reg [3:0] cust_ports;
    reg [3:0] uplink_ports;
    always @* begin
        for (j = 0; j < `VTF_NPORTS; j = j + 1) begin
            promisc[j] = (pcfg[j][`VTF_PCFG_PPT_LSB +: 2] == `VTF_PPT_PROMISC);
            cust_ports[j] = (pcfg[j][`VTF_PCFG_TUN_LSB +: 2] == `VTF_TUN_CUST);
            uplink_ports[j] = (pcfg[j][`VTF_PCFG_TUN_LSB +: 2] == `VTF_TUN_UPLINK);
        end
    end

    // Ingress classification
    wire [17:0] in_cfg = pcfg[cls_port];
    wire in_cust = (in_cfg[`VTF_PCFG_TUN_LSB +: 2] == `VTF_TUN_CUST);
    wire [3:0] in_bit = 4'h1 << cls_port;
    wire [11:0] eff_vid = (!cls_tagged || in_cust) ? in_cfg[11:0] : cls_vid;
    wire [11:0] cmd_vid = reg_wdata[11:0];

    // Table searches: frame VLAN, management VLAN, command VLAN, queried VLAN, free slot, count
    reg m_hit;
    reg [7:0] m_egr;
    reg [1:0] m_pvt;
    reg [11:0] m_prim;
    reg g_hit;
    reg [7:0] g_egr;
    reg [3:0] sec_mem;
    reg [7:0] p_egr;
    reg c_hit;
    reg [7:0] c_idx;
    reg q_hit;
    reg [7:0] q_egr;
    reg [1:0] q_pvt;
    reg [11:0] q_prim;
    reg f_any;
    reg [7:0] f_idx;
    reg [8:0] count;
    always @* begin
        m_hit = 1'b0;
        m_egr = 8'h00;
        m_pvt = `VTF_PVT_NONE;
        m_prim = 12'h000;
        g_hit = 1'b0;
        g_egr = 8'h00;
        sec_mem = 4'h0;
        p_egr = 8'h00;
        c_hit = 1'b0;
        c_idx = 8'h00;
        q_hit = 1'b0;
        q_egr = 8'h00;
        q_pvt = `VTF_PVT_NONE;
        q_prim = 12'h000;
        f_any = 1'b0;
        f_idx = 8'h00;
        count = 9'h000;
        for (i = `VTF_NSLOTS - 1; i >= 0; i = i - 1) begin
            if (tbl_valid[i]) begin
                count = count + 9'h001;
                if (tbl_vid[i] == eff_vid) begin
                    m_hit = 1'b1;
                    m_egr = tbl_egr[i];
                    m_pvt = tbl_pvt[i];
                    m_prim = tbl_prim[i];
                end
                if (tbl_vid[i] == mgmt_vid) begin
                    g_hit = 1'b1;
                    g_egr = tbl_egr[i];
                end
                if ((tbl_pvt[i] == `VTF_PVT_ISOLATED || tbl_pvt[i] == `VTF_PVT_COMMUNITY)
                        && tbl_prim[i] == eff_vid) begin
                    sec_mem = sec_mem | members(tbl_egr[i]);
                end
                if (tbl_vid[i] == cmd_vid) begin
                    c_hit = 1'b1;
                    c_idx = i[7:0];
                end
                if (tbl_vid[i] == query_vid) begin
                    q_hit = 1'b1;
                    q_egr = tbl_egr[i];
                    q_pvt = tbl_pvt[i];
                    q_prim = tbl_prim[i];
                end
            end else begin
                f_any = 1'b1;
                f_idx = i[7:0];
            end
        end
        // Primary of the frame's secondary VLAN
        for (i = 0; i < `VTF_NSLOTS; i = i + 1) begin
            if (tbl_valid[i] && tbl_vid[i] == m_prim && tbl_pvt[i] == `VTF_PVT_PRIMARY) begin
                p_egr = tbl_egr[i];
            end
        end
    end

    // Forwarding decision
    reg [3:0] mem;
    reg [3:0] fwd;
    reg drop;
    always @* begin
        mem = members(m_egr);
        case (m_pvt)
            `VTF_PVT_PRIMARY: fwd = (in_bit & promisc) != 4'h0 ? (mem | sec_mem) : mem;
            `VTF_PVT_ISOLATED: fwd = promisc & members(p_egr);
            `VTF_PVT_COMMUNITY: fwd = mem | (promisc & members(p_egr));
            default: fwd = mem;
        endcase
        fwd = fwd & ~in_bit;
        drop = !m_hit;
        if (in_cfg[`VTF_PCFG_TAGONLY_BIT] && !cls_tagged) begin
            drop = 1'b1;
        end
        if (in_cfg[`VTF_PCFG_FILT_BIT] && cls_tagged && (mem & in_bit) == 4'h0) begin
            drop = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            res_valid <= 1'b0;
            res_drop <= 1'b0;
            res_vid <= 12'h000;
            res_fwd_mask <= 4'h0;
            res_tag_mask <= 4'h0;
            res_strip_mask <= 4'h0;
            res_push_tag <= 1'b0;
            res_tag_word <= 32'h00000000;
            res_cpu_ok <= 1'b0;
        end else begin
            res_valid <= cls_valid;
            if (cls_valid) begin
                res_drop <= drop;
                res_vid <= eff_vid;
                res_fwd_mask <= drop ? 4'h0 : fwd;
                // Uplinks keep the outer tag, customer tunnel ports lose it
                res_tag_mask <= (tagged_ports(m_egr) | tagged_ports(p_egr) | uplink_ports) & ~cust_ports
                    & (drop ? 4'h0 : fwd);
                res_strip_mask <= drop ? 4'h0 : (cust_ports & fwd);
                res_push_tag <= !drop && in_cust && cls_tagged;
                res_tag_word <= {ptpid[cls_port], 4'h0, eff_vid};
                res_cpu_ok <= g_hit && (members(g_egr) & in_bit) != 4'h0;
            end
        end
    end

    // Register read and write decode
    wire [7:0] ra = araddr;
    always @* begin
        rd_ok = 1'b1;
        rd_word = 32'h00000000;
        if (ra == `VTF_A_MGMT) begin
            rd_word[11:0] = mgmt_vid;
        end else if (ra == `VTF_A_VCMD) begin
            rd_word[0] = refused;
            rd_word[`VTF_STAT_CNT_LSB +: 9] = count;
        end else if (ra == `VTF_A_VDATA) begin
            rd_word[21:0] = vdata;
        end else if (ra == `VTF_A_VQUERY) begin
            rd_word[0] = q_hit;
            rd_word[1] = q_hit && q_egr != 8'h00;
            rd_word[9:2] = q_egr;
            rd_word[11:10] = q_pvt;
            rd_word[23:12] = q_prim;
        end else if (ra >= `VTF_A_PCFG && ra < `VTF_A_PTPID && ra[1:0] == 2'h0) begin
            rd_word[17:0] = pcfg[ra[3:2]];
        end else if (ra >= `VTF_A_PTPID && ra < `VTF_A_SPAN && ra[1:0] == 2'h0) begin
            rd_word[15:0] = ptpid[ra[3:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Decoded from the captured address, which still stands when the write commits
    assign wr_ok = reg_waddr == `VTF_A_MGMT || reg_waddr == `VTF_A_VCMD || reg_waddr == `VTF_A_VDATA
        || reg_waddr == `VTF_A_VQUERY
        || (reg_waddr >= `VTF_A_PCFG && reg_waddr < `VTF_A_SPAN && reg_waddr[1:0] == 2'h0);

    // Byte lanes merge into the current contents of the addressed register, except at VCMD, where a command takes the write data as it stands
    reg [31:0] cur;
    always @* begin
        if (reg_waddr >= `VTF_A_PTPID) begin
            cur = {16'h0000, ptpid[reg_waddr[3:2]]};
        end else if (reg_waddr >= `VTF_A_PCFG) begin
            cur = {14'h0000, pcfg[reg_waddr[3:2]]};
        end else if (reg_waddr == `VTF_A_MGMT) begin
            cur = {20'h00000, mgmt_vid};
        end else if (reg_waddr == `VTF_A_VDATA) begin
            cur = {10'h000, vdata};
        end else begin
            cur = {20'h00000, query_vid};
        end
        wr_new = (cur & ~reg_wmask) | (reg_wdata & reg_wmask);
    end

    wire [1:0] cmd_op = reg_wdata[`VTF_CMD_OP_LSB +: 2];
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (n = 0; n < `VTF_NSLOTS; n = n + 1) begin
                tbl_valid[n] <= 1'b0;
                tbl_vid[n] <= 12'h000;
                tbl_egr[n] <= 8'h00;
                tbl_pvt[n] <= `VTF_PVT_NONE;
                tbl_prim[n] <= 12'h000;
            end
            tbl_valid[0] <= 1'b1;
            tbl_vid[0] <= `VTF_DEF_VID;
            tbl_egr[0] <= `VTF_EGR_ALL_UNTAG;
            for (n = 0; n < `VTF_NPORTS; n = n + 1) begin
                pcfg[n] <= {6'h00, `VTF_PORT_DEFAULT_VLAN_ID_RST};
                ptpid[n] <= `VTF_TPID_RST;
            end
            mgmt_vid <= `VTF_MGMT_RST;
            vdata <= 22'h000000;
            query_vid <= 12'h000;
            refused <= 1'b0;
        end else if (reg_we) begin
            if (reg_waddr == `VTF_A_MGMT) begin
                if (vid_legal(wr_new[11:0])) begin
                    mgmt_vid <= wr_new[11:0];
                end
            end else if (reg_waddr == `VTF_A_VDATA) begin
                vdata <= wr_new[21:0];
            end else if (reg_waddr == `VTF_A_VQUERY) begin
                query_vid <= wr_new[11:0];
            end else if (reg_waddr >= `VTF_A_PTPID) begin
                ptpid[reg_waddr[3:2]] <= wr_new[15:0];
            end else if (reg_waddr >= `VTF_A_PCFG) begin
                pcfg[reg_waddr[3:2]][17:12] <= wr_new[17:12];
                if (vid_legal(wr_new[11:0])) begin
                    pcfg[reg_waddr[3:2]][11:0] <= wr_new[11:0];
                end
            end else if (reg_waddr == `VTF_A_VCMD) begin
                refused <= 1'b0;
                case (cmd_op)
                    `VTF_OP_CREATE: begin
                        if (!vid_legal(cmd_vid) || c_hit || count == `VTF_MAX_VLANS || !f_any) begin
                            refused <= 1'b1;
                        end else begin
                            tbl_valid[f_idx] <= 1'b1;
                            tbl_vid[f_idx] <= cmd_vid;
                            tbl_egr[f_idx] <= 8'h00;
                            tbl_pvt[f_idx] <= `VTF_PVT_NONE;
                            tbl_prim[f_idx] <= 12'h000;
                        end
                    end
                    `VTF_OP_DELETE: begin
                        if (c_hit) begin
                            tbl_valid[c_idx] <= 1'b0;
                        end else begin
                            refused <= 1'b1;
                        end
                    end
                    `VTF_OP_SET: begin
                        if (c_hit) begin
                            tbl_egr[c_idx] <= vdata[7:0];
                            tbl_pvt[c_idx] <= vdata[`VTF_VDATA_PVT_LSB +: 2];
                            tbl_prim[c_idx] <= vdata[`VTF_VDATA_PRIM_LSB +: 12];
                        end else begin
                            refused <= 1'b1;
                        end
                    end
                    default: begin
                        refused <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// File: verif/vtf_engine_chk_sva.sv
// Concurrent checks on the ports of the VLAN tag filter engine
module vtf_engine_chk (
    input wire aclk,
    input wire aresetn,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire [31:0] rdata,
    input wire rvalid,
    input wire rready,
    input wire cls_valid,
    input wire [1:0] cls_port,
    input wire res_valid,
    input wire res_drop,
    input wire [11:0] res_vid,
    input wire [3:0] res_fwd_mask,
    input wire [3:0] res_tag_mask,
    input wire [3:0] res_strip_mask,
    input wire [31:0] res_tag_word
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_res_answer: assert property (cls_valid |=> res_valid)
        else $error("result missing after request");
    chk_res_pulse: assert property (!cls_valid |=> !res_valid)
        else $error("result without request");
    chk_drop_empty: assert property (res_valid && res_drop |-> res_fwd_mask == 4'h0)
        else $error("dropped frame forwarded");
    chk_no_hairpin: assert property (cls_valid |=> (res_fwd_mask & (4'h1 << $past(cls_port))) == 4'h0)
        else $error("frame sent back to ingress");
    chk_tag_word: assert property (res_valid |-> res_tag_word[15:0] == {4'h0, res_vid})
        else $error("tag word vid field wrong");
    chk_tag_within: assert property (res_valid |-> (res_tag_mask & ~res_fwd_mask) == 4'h0)
        else $error("tagged port outside forward set");
    chk_strip_untag: assert property (res_valid |-> (res_strip_mask & res_tag_mask) == 4'h0)
        else $error("strip port also tagged");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
endmodule

bind vtf_engine vtf_engine_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
    .bready, .rdata, .rvalid, .rready, .cls_valid, .cls_port, .res_valid, .res_drop, .res_vid, .res_fwd_mask,
    .res_tag_mask, .res_strip_mask, .res_tag_word);

// File: verif/vtf_frame_src.sv
// Neighbour node model that offers one frame per call to the classifier
module vtf_frame_src (
    input wire aclk,
    output logic cls_valid,
    output logic [1:0] cls_port,
    output logic cls_tagged,
    output logic [11:0] cls_vid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cls_valid = 1'b0;
        cls_port = 2'h0;
        cls_tagged = 1'b0;
        cls_vid = 12'hAAA;
    end
    task automatic send(input logic [1:0] p, input logic t, input logic [11:0] v);
        @(posedge aclk);
        cls_valid <= 1'b1;
        cls_port <= p;
        cls_tagged <= t;
        cls_vid <= v;
        @(posedge aclk);
        cls_valid <= 1'b0;
        // Idle port and VID lines flip so a stale value is never mistaken for a frame
        cls_vid <= ~v;
        cls_port <= ~p;
    endtask
endmodule

// File: verif/vtf_engine_test.sv
// Self-checking bench for the VLAN tag filter engine
module vtf_engine_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    wire awready, wready, bvalid, arready, rvalid, cls_valid, cls_tagged;
    wire res_valid, res_drop, res_push_tag, res_cpu_ok;
    wire [1:0] bresp, rresp, cls_port;
    wire [31:0] rdata, res_tag_word;
    wire [11:0] cls_vid, res_vid;
    wire [3:0] res_fwd_mask, res_tag_mask, res_strip_mask;
    int n_fail = 0, num_checks = 0, cyc = 0;
    logic [31:0] rd_v;
    logic [1:0] rsp;
    vtf_frame_src src (.aclk(aclk), .cls_valid(cls_valid), .cls_port(cls_port), .cls_tagged(cls_tagged),
        .cls_vid(cls_vid));
    vtf_engine DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cls_valid(cls_valid), .cls_port(cls_port), .cls_tagged(cls_tagged),
        .cls_vid(cls_vid), .res_valid(res_valid), .res_drop(res_drop), .res_vid(res_vid),
        .res_fwd_mask(res_fwd_mask), .res_tag_mask(res_tag_mask), .res_strip_mask(res_strip_mask),
        .res_push_tag(res_push_tag), .res_tag_word(res_tag_word), .res_cpu_ok(res_cpu_ok));
    always #50 aclk = ~aclk;
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            conclude;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e, input string n);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1;
        w = 1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready) begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 0;
            end
        end
        while (!bvalid) @(posedge aclk);
        rsp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    // Sends one frame and compares the decision; an empty forward set means a drop
    task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] v, input logic [11:0] ev,
        input logic [3:0] ef, input logic [3:0] et, input logic [3:0] es);
        src.send(p, t, v);
        #1;
        chk({res_valid, res_drop, res_fwd_mask, res_tag_mask, res_strip_mask}, {1'b1, ef == 0, ef, et, es}, "res");
        if (ef != 0) chk(res_vid, ev, "res_vid");
    endtask
    task t_defaults;
        rd(8'h00); chk(rd_v, 32'h1, "mgmt");
        rd(8'h20); chk(rd_v, 32'h8100, "tpid");
        wr(8'h0C, 32'h1); rd(8'h0C); chk(rd_v, 32'h157, "vlan1");
        rd(8'hFC); chk(rd_v, 32'h0, "unmapped rd"); chk(rsp, 2'h2, "unmapped rresp");
        wr(8'hFC, 32'h5); chk(rsp, 2'h2, "unmapped wr");
    endtask
    task t_create;
        wr(8'h04, 32'h1000); rd(8'h04); chk(rd_v, 32'h11, "vid 0");
        wr(8'h04, 32'h1FFF); rd(8'h04); chk(rd_v, 32'h11, "vid 4095");
        wr(8'h04, 32'h1005); rd(8'h04); chk(rd_v, 32'h20, "count");
        wr(8'h0C, 32'h5); rd(8'h0C); chk(rd_v, 32'h1, "unused");
        wr(8'h08, 32'h19); wr(8'h04, 32'h3005);
        wr(8'h0C, 32'h5); rd(8'h0C); chk(rd_v, 32'h67, "in use");
        for (int v = 12'h100; v < 12'h1FE; v++) wr(8'h04, 32'h1000 | v);
        wr(8'h04, 32'h11FE); rd(8'h04); chk(rd_v, 32'h1001, "full");
        wr(8'h04, 32'h2100); rd(8'h04); chk(rd_v, 32'hFF0, "delete");
    endtask
    task t_private;
        wr(8'h08, 32'h141); wr(8'h04, 32'h3101); wr(8'h08, 32'h40614); wr(8'h04, 32'h3102); wr(8'h10, 32'h20005);
        frm(2'h1, 1, 12'h102, 12'h102, 4'h1, 4'h0, 4'h0);
        frm(2'h0, 1, 12'h101, 12'h101, 4'hE, 4'h0, 4'h0);
        wr(8'h08, 32'h40714); wr(8'h04, 32'h3102);
        frm(2'h1, 1, 12'h102, 12'h102, 4'h5, 4'h0, 4'h0);
    endtask
    task t_class;
        wr(8'h10, 32'h5);
        frm(2'h0, 0, 12'h0, 12'h5, 4'h6, 4'h2, 4'h0);
        chk({res_push_tag, res_tag_word}, {1'b0, 32'h81000005}, "word");
        frm(2'h2, 1, 12'h5, 12'h5, 4'h3, 4'h2, 4'h0);
        frm(2'h2, 1, 12'h9, 12'h9, 4'h0, 4'h0, 4'h0);
        wr(8'h1C, 32'hC001);
        frm(2'h3, 0, 12'h0, 12'h1, 4'h0, 4'h0, 4'h0);
        frm(2'h3, 1, 12'h5, 12'h5, 4'h0, 4'h0, 4'h0);
        frm(2'h3, 1, 12'h1, 12'h1, 4'h7, 4'h0, 4'h0);
        chk(res_cpu_ok, 1'b1, "cpu ok");
        wr(8'h00, 32'h5); wr(8'h00, 32'h0); rd(8'h00); chk(rd_v, 32'h5, "mgmt vid");
        frm(2'h3, 1, 12'h1, 12'h1, 4'h7, 4'h0, 4'h0);
        chk(res_cpu_ok, 1'b0, "cpu barred");
    endtask
    task t_tunnel;
        wr(8'h14, 32'h1005); wr(8'h24, 32'h88A8);
        frm(2'h1, 1, 12'h7, 12'h5, 4'h5, 4'h0, 4'h0);
        chk({res_push_tag, res_tag_word}, {1'b1, 32'h88A80005}, "push");
        frm(2'h0, 0, 12'h0, 12'h5, 4'h6, 4'h0, 4'h2);
        wr(8'h18, 32'h2005);
        frm(2'h0, 0, 12'h0, 12'h5, 4'h6, 4'h4, 4'h2);
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        t_defaults;
        t_create;
        t_class;
        t_private;
        t_tunnel;
        conclude;
    end
endmodule
